// file: rsc_delay.sv
`timescale 1ns/1ps
module rsc_delay import rsc_pkg::*; #(
	parameter int DLY_W = RSC_DLY_W
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic req,
	input wire logic [DLY_W-1:0] period,
	output logic busy
);
	initial begin
		if (DLY_W < 2) begin
			$error("rsc_delay: DLY_W too small");
		end
	end
	typedef struct packed {
		logic [DLY_W-1:0] cnt;
		logic run;
	} rsc_dly_st_t;
	rsc_dly_st_t st_reg;
	rsc_dly_st_t st_next;
	// Restarts from full period each time the request drops
	always_comb begin
		st_next = st_reg;
		if (req) begin
			st_next.cnt = period;
			st_next.run = 1'b1;
		end else if (st_reg.run) begin
			if (st_reg.cnt <= DLY_W'(1)) begin
				st_next.run = 1'b0;
				st_next.cnt = '0;
			end else begin
				st_next.cnt = st_reg.cnt - DLY_W'(1);
			end
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '{cnt: '0, run: 1'b1};
		end else begin
			st_reg <= st_next;
		end
	end
	assign busy = st_reg.run;
endmodule : rsc_delay

// file: rsc_pkg.sv
package rsc_pkg;
	localparam int RSC_ADDR_W = 4;
	localparam int RSC_DATA_W = 8;
	localparam logic [3:0] RSC_CAUSE_OFS = 4'h0;
	localparam logic [3:0] RSC_CTRL_OFS = 4'h1;
	localparam logic [3:0] RSC_STAT_OFS = 4'h2;
	localparam int RSC_WATCHDOG_RESET_FLAG_BIT = 3;
	localparam int RSC_BROWNOUT_RESET_FLAG_BIT = 2;
	localparam int RSC_PIN_RESET_FLAG_BIT = 1;
	localparam int RSC_POWER_ON_RESET_FLAG_BIT = 0;
	localparam int RSC_CTRL_ADC_BIT = 0;
	localparam int RSC_CTRL_ACBG_BIT = 1;
	localparam int RSC_DLY_W = 16;
	// Minimum brown-out persistence, ns, and its cycle count at 10 MHz
	localparam int RSC_BOD_MIN_NS = 2000;
	localparam int RSC_CLK_NS = 100;
	localparam int RSC_BOD_CYC = (RSC_BOD_MIN_NS + RSC_CLK_NS - 1) / RSC_CLK_NS;
	localparam logic [RSC_DLY_W-1:0] RSC_DLY_ONE = 16'h0001;

	typedef struct packed {
		logic power_on;
		logic pin_low;
		logic wdt_expire;
		logic wdt_reset_mode;
		logic bod_low;
	} rsc_src_t;

	typedef struct packed {
		logic [RSC_ADDR_W-1:0] addr;
		logic [RSC_DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} rsc_bus_t;
endpackage : rsc_pkg

// file: rsc_src_model.sv
`timescale 1ns/1ps
module rsc_src_model (
	input wire logic clk,
	output logic power_on_n,
	output logic reset_pin_n,
	output logic wdt_expire,
	output logic wdt_reset_mode,
	output logic bod_below
);
	// Supply starts below the power-on level, as at a real power-up
	initial begin
		power_on_n = 1'b0;
		reset_pin_n = 1'b1;
		wdt_expire = 1'b0;
		wdt_reset_mode = 1'b0;
		bod_below = 1'b0;
	end
	// Source 0 supply, 1 pin, else brown-out; held active for n cycles
	task automatic drop(input int src, input int n);
		@(posedge clk);
		case (src)
			0: power_on_n <= 1'b0;
			1: reset_pin_n <= 1'b0;
			default: bod_below <= 1'b1;
		endcase
		repeat (n) @(posedge clk);
		power_on_n <= 1'b1;
		reset_pin_n <= 1'b1;
		bod_below <= 1'b0;
	endtask : drop
	task automatic wdt_fire(input logic mode);
		@(posedge clk);
		wdt_reset_mode <= mode;
		wdt_expire <= 1'b1;
		@(posedge clk);
		wdt_expire <= 1'b0;
	endtask : wdt_fire
endmodule : rsc_src_model

// file: rsc_sync.sv
`timescale 1ns/1ps
module rsc_sync import rsc_pkg::*; #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
	} rsc_sync_st_t;
	rsc_sync_st_t st_reg;
	rsc_sync_st_t st_next;
	always_comb begin
		st_next.s1 = d;
		st_next.s2 = st_reg.s1;
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
	assign q = st_reg.s2;
endmodule : rsc_sync

// file: rsc_top.sv
// Functional notes
// - Reset loads I/O registers, core restarts
// - Power-on and enabled pin reset outputs asynchronously
// - Delay counter stretches reset after sources
// - Four causes each assert internal reset
// - Power-on release starts delay, drop immediate
// - Pin low resets clocklessly, delay after
// - Disable fuse ignores reset pin
// - Brown-out asserts after sync and BOD_CYC cycles, delay on recovery
// - Short supply dips ignored by brown-out
// - Watchdog resets only in reset mode
// - Watchdog pulse one cycle, delay after
// - Cause bits seven to four read zero
// - Watchdog flag bit3, cleared POR/write zero
// - Brown-out flag bit2, cleared POR/write zero
// - Pin flag bit1, cleared POR/write zero
// - Power-on flag bit0, only write zero
// - Bandgap on for detector, comparator, converter
//
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
module rsc_top import rsc_pkg::*; #(
	parameter int DLY_W = RSC_DLY_W,
	parameter int BOD_CYC = RSC_BOD_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic power_on_n,
	input wire logic reset_pin_n,
	input wire logic pin_reset_disable_fuse,
	input wire logic wdt_expire,
	input wire logic wdt_reset_mode,
	input wire logic brownout_detector_en,
	input wire logic bod_below,
	input wire logic [DLY_W-1:0] startup_delay_period,
	input wire logic [RSC_ADDR_W-1:0] addr,
	input wire logic [RSC_DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [RSC_DATA_W-1:0] rdata,
	output logic sys_reset_n,
	output logic io_reset_n,
	output logic bandgap_en
);
	initial begin
		if (BOD_CYC < 1 || BOD_CYC > 255) begin
			$error("rsc_top: BOD_CYC out of range");
		end
	end

	typedef enum logic [2:0] {
		RSC_ST_HOLD = 3'b001,
		RSC_ST_STRETCH = 3'b010,
		RSC_ST_RUN = 3'b100
	} rsc_state_t;

	typedef struct packed {
		rsc_state_t state;
		logic [3:0] flags;
		logic [1:0] ctrl;
		logic [7:0] bod_cnt;
		logic bod_rst;
		logic wdt_pulse;
		logic [RSC_DATA_W-1:0] rdata;
	} rsc_st_t;

	rsc_st_t st_reg;
	rsc_st_t st_next;
	rsc_bus_t bus;
	rsc_src_t src;
	logic [2:0] pin_sync;
	logic pin_low_s;
	logic por_s;
	logic pin_active;
	logic any_req;
	logic dly_busy;
	logic async_rst_n;

	assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

	// Sampled copies feed state and flags; raw pins only force reset asynchronously
	rsc_sync #(.WIDTH(3)) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.d({~power_on_n, ~reset_pin_n, bod_below}),
		.q(pin_sync)
	);
	assign pin_low_s = pin_sync[1];
	assign por_s = pin_sync[2];

	assign src.power_on = ~power_on_n;
	assign src.pin_low = ~reset_pin_n;
	assign src.wdt_expire = wdt_expire;
	assign src.wdt_reset_mode = wdt_reset_mode;
	assign src.bod_low = pin_sync[0];

	assign pin_active = pin_low_s & ~pin_reset_disable_fuse;

	// Asynchronous path keeps I/O in reset with no clock running
	assign async_rst_n = ~(src.power_on | (src.pin_low & ~pin_reset_disable_fuse));

	// Single request from all causes
	assign any_req = por_s | pin_active | st_reg.bod_rst | st_reg.wdt_pulse;

	rsc_delay #(.DLY_W(DLY_W)) u_delay (
		.clk(clk),
		// Not cleared by the raw sources, so a released supply still sees the full delay
		.rst_n(rst_n),
		.req(any_req),
		.period(startup_delay_period),
		.busy(dly_busy)
	);

	function automatic logic [3:0] rsc_clear_w(input logic [3:0] cur, input logic [7:0] d);
		rsc_clear_w = cur & d[3:0];
	endfunction : rsc_clear_w

	always_comb begin
		st_next = st_reg;
		st_next.rdata = '0;
		// Brown-out filter: low must persist BOD_CYC cycles
		if (brownout_detector_en && src.bod_low) begin
			if (st_reg.bod_cnt >= 8'(BOD_CYC - 1)) begin
				st_next.bod_rst = 1'b1;
			end else begin
				st_next.bod_cnt = st_reg.bod_cnt + 8'h01;
			end
		end else begin
			st_next.bod_cnt = 8'h00;
			st_next.bod_rst = 1'b0;
		end
		// Watchdog pulse is one cycle; falling edge releases to delay
		st_next.wdt_pulse = src.wdt_expire & src.wdt_reset_mode & ~st_reg.wdt_pulse;
		// Software write of zero clears; hardware set wins below
		if (bus.wr && bus.addr == RSC_CAUSE_OFS) begin
			st_next.flags = rsc_clear_w(st_reg.flags, bus.wdata);
		end
		if (bus.wr && bus.addr == RSC_CTRL_OFS) begin
			st_next.ctrl = bus.wdata[1:0];
		end
		if (st_reg.wdt_pulse) begin
			st_next.flags[RSC_WATCHDOG_RESET_FLAG_BIT] = 1'b1;
		end
		if (st_next.bod_rst && !st_reg.bod_rst) begin
			st_next.flags[RSC_BROWNOUT_RESET_FLAG_BIT] = 1'b1;
		end
		if (pin_active) begin
			st_next.flags[RSC_PIN_RESET_FLAG_BIT] = 1'b1;
		end
		if (por_s) begin
			st_next.flags = 4'h0;
			st_next.flags[RSC_POWER_ON_RESET_FLAG_BIT] = 1'b1;
		end
		case (st_reg.state)
			RSC_ST_HOLD: begin
				if (!any_req) begin
					st_next.state = RSC_ST_STRETCH;
				end
			end
			RSC_ST_STRETCH: begin
				if (any_req) begin
					st_next.state = RSC_ST_HOLD;
				end else if (!dly_busy) begin
					st_next.state = RSC_ST_RUN;
				end
			end
			RSC_ST_RUN: begin
				if (any_req) begin
					st_next.state = RSC_ST_HOLD;
				end
			end
			default: begin
				st_next.state = RSC_ST_HOLD;
			end
		endcase
		if (bus.rd) begin
			case (bus.addr)
				RSC_CAUSE_OFS: st_next.rdata = {4'h0, st_reg.flags};
				RSC_CTRL_OFS: st_next.rdata = {6'h00, st_reg.ctrl};
				RSC_STAT_OFS: st_next.rdata = {5'h00, st_reg.state};
				default: st_next.rdata = '0;
			endcase
		end
	end

	// Only rst_n clears control state; power-on and pin leave ctrl unchanged, power-on sets flags to 4'h1
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '{state: RSC_ST_HOLD, flags: 4'h0, ctrl: 2'h0, bod_cnt: 8'h00,
				bod_rst: 1'b0, wdt_pulse: 1'b0, rdata: '0};
		end else begin
			st_reg <= st_next;
		end
	end

	assign rdata = st_reg.rdata;
	// Internal reset held until stretch done; drop is immediate
	assign sys_reset_n = async_rst_n & (st_reg.state == RSC_ST_RUN) & ~any_req;
	assign io_reset_n = sys_reset_n;
	assign bandgap_en = brownout_detector_en | st_reg.ctrl[RSC_CTRL_ACBG_BIT]
		| st_reg.ctrl[RSC_CTRL_ADC_BIT];
endmodule : rsc_top

// file: rsc_top_assertions.sv
`timescale 1ns/1ps
module rsc_chk import rsc_pkg::*; #(
	parameter int DLY_W = RSC_DLY_W,
	parameter int BOD_CYC = RSC_BOD_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic power_on_n,
	input wire logic reset_pin_n,
	input wire logic pin_reset_disable_fuse,
	input wire logic wdt_expire,
	input wire logic wdt_reset_mode,
	input wire logic brownout_detector_en,
	input wire logic bod_below,
	input wire logic [DLY_W-1:0] startup_delay_period,
	input wire logic rd,
	input wire logic [RSC_DATA_W-1:0] rdata,
	input wire logic sys_reset_n,
	input wire logic io_reset_n,
	input wire logic bandgap_en
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	a_src_forces: assert property (!power_on_n || (!reset_pin_n && !pin_reset_disable_fuse) |-> !sys_reset_n)
		else $error("active source left reset released");
	a_io_same: assert property (io_reset_n == sys_reset_n)
		else $error("io reset differs from system reset");
	a_io_forced: assert property (!power_on_n || (!reset_pin_n && !pin_reset_disable_fuse) |-> !io_reset_n)
		else $error("active source left io reset released");
	a_stretch_held: assert property ($rose(power_on_n) && startup_delay_period >= 4 |-> !sys_reset_n [*4])
		else $error("reset released before delay");
	a_release_cause: assert property ($rose(sys_reset_n) |-> $past(power_on_n, 4))
		else $error("reset released too soon after supply");
	a_wdt_resets: assert property (wdt_expire && wdt_reset_mode |-> ##[1:2] !sys_reset_n)
		else $error("watchdog expiry gave no reset");
	a_wdt_ignored: assert property (wdt_expire && !wdt_reset_mode && sys_reset_n && power_on_n && reset_pin_n |=> sys_reset_n)
		else $error("watchdog reset outside reset mode");
	a_bod_short: assert property (sys_reset_n && !bod_below ##1 bod_below ##1 !bod_below |-> sys_reset_n [*4])
		else $error("short dip caused brown-out");
	a_reserved_zero: assert property (rd |=> rdata[7:4] == 4'h0)
		else $error("reserved cause bits not zero");
	a_bandgap_bod: assert property (brownout_detector_en |-> bandgap_en)
		else $error("reference off with detector on");
endmodule : rsc_chk
bind rsc_top rsc_chk #(.DLY_W(DLY_W), .BOD_CYC(BOD_CYC)) u_rsc_chk (.*);

// file: rsc_top_bench.sv
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin bad_count++; $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module rsc_top_bench import rsc_pkg::*;;
	logic clk = 0, rst_n = 0, wr = 0, rd = 0;
	logic pin_reset_disable_fuse = 0, brownout_detector_en = 0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00, rdata;
	logic [15:0] startup_delay_period = 16'h0004;
	logic power_on_n, reset_pin_n, wdt_expire, wdt_reset_mode, bod_below;
	logic sys_reset_n, io_reset_n, bandgap_en;
	int bad_count = 0, n_tests = 0;
	rsc_top #(.BOD_CYC(2)) u_rsc_top (.*);
	rsc_src_model u_rsc_src_model (.*);
	initial begin
		forever #50 clk = ~clk;
	end
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 `CHK(rdata, e)
	endtask : rd_chk
	// Bounded so a stuck reset fails here rather than at the watchdog
	task automatic wait_run(input int lo);
		int c;
		c = 0;
		#1;
		while (sys_reset_n !== 1'b1 && c < 60) begin
			@(posedge clk);
			#1;
			c++;
		end
		`CHK(c >= lo && c < 60, 1'b1)
	endtask : wait_run
	task automatic test_done;
		$display("bad_count=%0d n_tests=%0d", bad_count, n_tests);
		if (bad_count == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : test_done
	initial begin
		repeat (3000) @(posedge clk);
		bad_count++;
		test_done();
	end
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		u_rsc_src_model.drop(0, 3);
		wait_run(4);
		rd_chk(4'h0, 8'h01);
		wr_reg(4'h0, 8'hFF);
		rd_chk(4'h0, 8'h01);
		wr_reg(4'h0, 8'h00);
		rd_chk(4'h0, 8'h00);
		u_rsc_src_model.drop(1, 4);
		wait_run(4);
		rd_chk(4'h0, 8'h02);
		wr_reg(4'h0, 8'h00);
		pin_reset_disable_fuse <= 1'b1;
		// Look while the pin is still low, not only after its release
		fork
			u_rsc_src_model.drop(1, 4);
			begin
				repeat (3) @(posedge clk);
				#1 `CHK(sys_reset_n, 1'b1)
			end
		join
		#1 `CHK(sys_reset_n, 1'b1)
		u_rsc_src_model.wdt_fire(1'b0);
		repeat (3) @(posedge clk);
		rd_chk(4'h0, 8'h00);
		u_rsc_src_model.wdt_fire(1'b1);
		wait_run(4);
		rd_chk(4'h0, 8'h08);
		brownout_detector_en <= 1'b1;
		u_rsc_src_model.drop(2, 1);
		repeat (4) @(posedge clk);
		#1 `CHK(sys_reset_n, 1'b1)
		u_rsc_src_model.drop(2, 6);
		wait_run(4);
		rd_chk(4'h0, 8'h0C);
		u_rsc_src_model.drop(0, 3);
		wait_run(4);
		rd_chk(4'h0, 8'h01);
		`CHK(bandgap_en, 1'b1)
		brownout_detector_en <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			wr_reg(4'h1, 8'(i));
			#1 `CHK(bandgap_en, i != 0)
			// Detector off: allow the reference to settle before any result is used
			repeat (4) @(posedge clk);
		end
		rd_chk(4'hF, 8'h00);
		test_done();
	end
endmodule : rsc_top_bench
